/* tb/ccb_card_model.sv */
/*
  Interface card on the expansion bus holding one byte.
  Assumes the board's io select and read/write are registered.
*/
module ccb_card_model
(
  input  wire logic       i_clk,
  input  wire logic       i_sel_n,
  input  wire logic       i_rd_wr,
  input  wire logic [7:0] i_data,
  input  wire logic       i_data_oe,
  output logic      [7:0] o_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] store_reg;
  logic [7:0] idle_reg;
  // Released bus inverts every cycle, so a stale byte shows only on every other cycle
  always_ff @(posedge i_clk)
  begin
    idle_reg <= ~o_data;
    if (!i_sel_n && i_rd_wr && i_data_oe)
      store_reg <= i_data;
  end
  always_comb
  begin
    if (!i_sel_n && !i_rd_wr)
      o_data = store_reg;
    else if (i_data_oe)
      o_data = i_data;
    else
      o_data = idle_reg;
  end
endmodule // ccb_card_model

/* tb/ccb_checker.sv */
/*
  Port checks for the processor glue block.
  Assumes one 100 MHz clock and a synchronous active-high reset.
*/
module ccb_checker
(
  input wire logic        I_CLOCK,
  input wire logic        I_RST,
  input wire logic        i_RESET_BUTTON_N,
  input wire logic        i_CPU_PHASE_TWO_CLOCK,
  input wire logic [15:0] i_CPU_ADDR,
  input wire logic        o_CPU_CLOCK,
  input wire logic        o_SER_CLOCK,
  input wire logic        o_SER_RESET,
  input wire logic        o_CPU_RESET_N,
  input wire logic [15:0] o_BUS_ADDR,
  input wire logic        o_BUS_DATA_OE,
  input wire logic        o_CPU_DATA_OE,
  input wire logic        o_BUS_RD_WR,
  input wire logic        o_IO_DATA_BUFFER_ENABLE_N,
  input wire logic        o_RAM_SEL_N,
  input wire logic        o_ROM_SEL_N
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (I_RST);

  // ----------------------------------------------------------------------
  // Release counter, restarted by the button
  // ----------------------------------------------------------------------
  logic [23:0] held_reg;
  logic [23:0] held_next;
  always_comb
  begin
    held_next = held_reg + 24'h1;
    if (I_RST || !i_RESET_BUTTON_N)
      held_next = 24'h0;
    else if (held_reg == 24'hFFFFFF)
      held_next = held_reg;
  end
  always_ff @(posedge I_CLOCK)
    held_reg <= held_next;

  sequence s_cpu_period;
    ##50 $fell(o_CPU_CLOCK) ##50 $rose(o_CPU_CLOCK);
  endsequence
  sequence s_ser_period;
    ##10 $fell(o_SER_CLOCK) ##10 $rose(o_SER_CLOCK);
  endsequence

  a_cpu_clk_rate: assert property ($rose(o_CPU_CLOCK) |-> s_cpu_period)
    else $error("cpu clock period wrong");
  a_ser_clk_rate: assert property ($rose(o_SER_CLOCK) |-> s_ser_period)
    else $error("serial clock period wrong");
  a_reset_pair: assert property (o_SER_RESET != o_CPU_RESET_N)
    else $error("resets not paired");
  a_reset_press: assert property ($fell(i_RESET_BUTTON_N) |->
    ##[1:6] (o_SER_RESET && !o_CPU_RESET_N)) else $error("button ignored");
  a_hold_min: assert property ($fell(o_SER_RESET) |->
    held_reg >= ccb_pkg::RST_HOLD_CYC) else $error("reset released early");
  a_addr_follow: assert property (1'b1 |=>
    o_BUS_ADDR == $past(i_CPU_ADDR)) else $error("bus address stale");
  // Processor reset output lags the internal hold by one cycle, so the
  // enable is owed only where that output already shows release
  a_io_select: assert property (
    (i_CPU_ADDR[15:8] == ccb_pkg::IO_PAGE) |=>
    (!o_IO_DATA_BUFFER_ENABLE_N || !o_CPU_RESET_N)) else $error("io missed");
  a_io_other: assert property (
    (i_CPU_ADDR[15:8] != ccb_pkg::IO_PAGE) |=> o_IO_DATA_BUFFER_ENABLE_N)
    else $error("io outside page");
  a_mem_inhibit: assert property (!o_IO_DATA_BUFFER_ENABLE_N |->
    o_RAM_SEL_N && o_ROM_SEL_N) else $error("memory not inhibited");
  a_buffer_off: assert property (o_IO_DATA_BUFFER_ENABLE_N |->
    !o_BUS_DATA_OE) else $error("bus driven outside io");
  a_read_dir: assert property (
    !o_IO_DATA_BUFFER_ENABLE_N && !o_BUS_RD_WR |->
    o_CPU_DATA_OE && !o_BUS_DATA_OE) else $error("read direction");
  a_write_phase: assert property (
    $rose(o_BUS_DATA_OE) |-> o_BUS_RD_WR &&
    ($past(i_CPU_PHASE_TWO_CLOCK, 2) || $past(i_CPU_PHASE_TWO_CLOCK, 3)
    || $past(i_CPU_PHASE_TWO_CLOCK, 4))) else $error("write without phase");
endmodule // ccb_checker

/* tb/ccb_tb_top.sv */
/*
  Self-checking bench for the glue block with a card on the bus.
  Assumes package constants; inputs change on falling edges.
*/
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
  failures++; $display("[FAIL] %s exp %0h got %0h", n, e, g); \
  end end
module ccb_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        I_CLOCK = 1'b0;
  logic        I_RST = 1'b1;
  logic        btn_n = 1'b1;
  logic        ph2 = 1'b0;
  logic        rw = 1'b1;
  logic [15:0] addr = 16'h0410;
  logic [7:0]  wdat = 8'h00;
  logic [7:0]  bus_in, bus_out, cpu_dat;
  logic [15:0] bus_addr;
  logic        bus_oe, cpu_oe, cpu_clk, ser_clk, ser_rst, cpu_rst_n;
  logic        rd_wr, io_en_n, ram_n, rom_n;
  int          failures = 0;
  int          total_checks = 0;
  int          cyc = 0;

  always #5 I_CLOCK = ~I_CLOCK;

  ccb_top ccb_top_i (.I_CLOCK(I_CLOCK), .I_RST(I_RST),
    .i_RESET_BUTTON_N(btn_n), .i_CPU_PHASE_ONE(!ph2),
    .i_CPU_PHASE_TWO_CLOCK(ph2), .i_CPU_ADDR(addr), .i_CPU_DATA(wdat),
    .i_CPU_RD_WR(rw), .i_BUS_DATA(bus_in), .o_CPU_CLOCK(cpu_clk),
    .o_SER_CLOCK(ser_clk), .o_SER_RESET(ser_rst),
    .o_CPU_RESET_N(cpu_rst_n), .o_BUS_ADDR(bus_addr),
    .o_BUS_DATA(bus_out), .o_BUS_DATA_OE(bus_oe), .o_CPU_DATA(cpu_dat),
    .o_CPU_DATA_OE(cpu_oe), .o_BUS_RD_WR(rd_wr),
    .o_IO_DATA_BUFFER_ENABLE_N(io_en_n), .o_RAM_SEL_N(ram_n),
    .o_ROM_SEL_N(rom_n));
  ccb_card_model ccb_card_model_i (.i_clk(I_CLOCK), .i_sel_n(io_en_n),
    .i_rd_wr(rd_wr), .i_data(bus_out), .i_data_oe(bus_oe),
    .o_data(bus_in));

  task automatic test_done();
    if (failures == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(negedge I_CLOCK);
  endtask

  // Io address stands during the hold, so the io enable must stay off
  task automatic chk_hold();
    step(ccb_pkg::RST_HOLD_CYC - 2);
    `CHK("cpu reset held", 1'b0, cpu_rst_n)
    `CHK("ser reset held", 1'b1, ser_rst)
    `CHK("io off in reset", 1'b1, io_en_n)
    step(12);
    `CHK("cpu reset free", 1'b1, cpu_rst_n)
    `CHK("ser reset free", 1'b0, ser_rst)
  endtask

  task automatic t_clocks();
    logic pc, ps;
    int   nc, ns;
    pc = cpu_clk;
    ps = ser_clk;
    nc = 0;
    ns = 0;
    repeat (1000)
    begin
      step(1);
      nc += int'(cpu_clk & !pc);
      ns += int'(ser_clk & !ps);
      pc = cpu_clk;
      ps = ser_clk;
    end
    `CHK("cpu clock edges", 10, nc)
    `CHK("ser clock edges", 50, ns)
  endtask

  task automatic t_decode();
    logic [15:0] tb[6] = '{16'h03FF, 16'h0400, 16'h04FF, 16'h0500,
                           16'h8000, 16'hFFF0};
    foreach (tb[k])
    begin
      addr = tb[k];
      step(2);
      `CHK("bus addr", tb[k], bus_addr)
      `CHK("io enable", tb[k][15:8] != 8'h04, io_en_n)
      `CHK("ram sel", tb[k][15] | (tb[k][15:8] == 8'h04), ram_n)
      `CHK("rom sel", !tb[k][15], rom_n)
    end
  endtask

  // Write waits for phase two; read turns the buffer round
  task automatic t_io();
    addr = 16'h0410;
    wdat = 8'h5A;
    step(6);
    `CHK("bus oe no phase", 1'b0, bus_oe)
    ph2 = 1'b1;
    step(6);
    `CHK("bus oe write", 1'b1, bus_oe)
    `CHK("bus data", 8'h5A, bus_out)
    `CHK("cpu oe write", 1'b0, cpu_oe)
    ph2 = 1'b0;
    step(6);
    rw = 1'b0;
    step(3);
    `CHK("cpu oe read", 1'b1, cpu_oe)
    `CHK("cpu data", 8'h5A, cpu_dat)
    `CHK("bus oe read", 1'b0, bus_oe)
    addr = 16'h0500;
    step(3);
    `CHK("cpu oe ram", 1'b0, cpu_oe)
  endtask

  // Bytes stored in the RAM copy must come back at the vector cells;
  // address is held until phase two has left the synchroniser
  task automatic t_vector();
    logic [7:0] vb[6] = '{8'h3C, 8'hC3, 8'h96, 8'h69, 8'h5A, 8'hA5};
    rw = 1'b1;
    foreach (vb[k])
    begin
      addr = ccb_pkg::VEC_RAM_BASE + 16'(k);
      wdat = vb[k];
      ph2  = 1'b1;
      step(5);
      ph2  = 1'b0;
      step(5);
    end
    rw = 1'b0;
    foreach (vb[k])
    begin
      addr = ccb_pkg::VEC_BOOT_LO + 16'(k);
      step(3);
      `CHK("vector oe", 1'b1, cpu_oe)
      `CHK("vector byte", vb[k], cpu_dat)
    end
  endtask

  task automatic t_button();
    btn_n = 1'b0;
    step(8);
    `CHK("ser reset press", 1'b1, ser_rst)
    `CHK("cpu reset press", 1'b0, cpu_rst_n)
    addr = 16'h0410;
    btn_n = 1'b1;
    chk_hold();
  endtask

  always @(posedge I_CLOCK)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      failures++;
      test_done();
    end
  end

  initial
  begin
    step(6);
    I_RST = 1'b0;
    chk_hold();
    t_clocks();
    t_decode();
    t_io();
    t_vector();
    t_button();
    test_done();
  end
endmodule // ccb_tb_top

bind ccb_top ccb_checker ccb_checker_i (.I_CLOCK, .I_RST, .i_RESET_BUTTON_N,
  .i_CPU_PHASE_TWO_CLOCK, .i_CPU_ADDR, .o_CPU_CLOCK, .o_SER_CLOCK,
  .o_SER_RESET, .o_CPU_RESET_N, .o_BUS_ADDR, .o_BUS_DATA_OE, .o_CPU_DATA_OE,
  .o_BUS_RD_WR, .o_IO_DATA_BUFFER_ENABLE_N, .o_RAM_SEL_N, .o_ROM_SEL_N);

/* verilog/ccb_pkg.sv */
/*
  Constants, types and encodings for the processor glue block: clock
  dividers, reset stretch, vector addresses, I/O page decode.
  Assumes a single 100 MHz system clock and synchronous reset.
*/
// Behaviour
// - The block feeds a 1 MHz clock to the processor, which returns two non-overlapping phases from it.
// - Every processor read and write, including expansion bus ones, is timed by phase two; the block gates only writes by phase two, not reads.
// - The serial controller gets its own clock near 5.068 MHz, a 5 MHz source being acceptable.
// - Power-up or button drive serial reset high and processor reset low, and both release together.
// - The high serial reset returns the serial controller state machine to its initial state.
// - After processor reset release the processor fetches bytes at FFFA and FFFB as its start address.
// - Reset, NMI, IRQ and software interrupt each fetch a two-byte vector, IRQ and software sharing one.
// - Fixed vectors redirect to RAM cells set up by firmware and rewritable by users.
// - The address buffers are always enabled so the bus address follows the processor address.
// - Data buffer direction follows read/write: low carries bus to processor, high processor to bus.
// - The data buffer connects only while the low I/O data enable is asserted, otherwise it is off; processor data enable also asserts for FFFA..FFFF.
// - I/O enable and selects assert only for 0400H to 04FFH, and RAM and ROM are inhibited then.
package ccb_pkg;

  // ----------------------------------------------------------------------
  // Clock figures
  // ----------------------------------------------------------------------
  localparam int SYS_CLK_HZ     = 100_000_000;
  localparam int CPU_CLK_HZ     = 1_000_000;
  localparam int SER_CLK_HZ     = 5_000_000;
  localparam int CPU_HALF_CYC   = SYS_CLK_HZ / CPU_CLK_HZ / 2;
  localparam int SER_HALF_CYC   = SYS_CLK_HZ / SER_CLK_HZ / 2;
  localparam int DIV_W          = 6;
  localparam logic [DIV_W-1:0] CPU_HALF_LAST = DIV_W'(CPU_HALF_CYC - 1);
  localparam logic [DIV_W-1:0] SER_HALF_LAST = DIV_W'(SER_HALF_CYC - 1);
  // Gap between phases so they never overlap
  localparam logic [DIV_W-1:0] PHASE_GAP     = 6'h02;

  // ----------------------------------------------------------------------
  // Reset stretch
  // ----------------------------------------------------------------------
  localparam int RST_HOLD_US    = 100;
  localparam int RST_HOLD_CYC   = RST_HOLD_US * (SYS_CLK_HZ / 1_000_000);
  localparam int RST_W          = 24;

  // ----------------------------------------------------------------------
  // Vectors and address decode
  // ----------------------------------------------------------------------
  localparam logic [15:0] VEC_NMI_LO = 16'hFFFA;
  localparam logic [15:0] VEC_RST_LO = 16'hFFFC;
  localparam logic [15:0] VEC_IRQ_LO = 16'hFFFE;
  localparam logic [15:0] VEC_BOOT_LO = 16'hFFFA;
  localparam logic [15:0] VEC_BOOT_HI = 16'hFFFB;
  localparam logic [7:0]  IO_PAGE    = 8'h04;
  localparam logic [7:0]  ROM_BIT    = 8'h80;
  localparam int          VEC_RAM_WORDS = 8;
  localparam logic [15:0] VEC_RAM_BASE  = 16'h0200;

  typedef enum logic [1:0] {
    VEC_NMI = 2'h0,
    VEC_RST = 2'h1,
    VEC_IRQ = 2'h2
  } ccb_vec_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        rd_wr;
  } ccb_cpu_bus_t;

  typedef struct packed {
    logic ram_sel_n;
    logic rom_sel_n;
    logic io_data_buffer_enable_n;
  } ccb_sel_t;

endpackage : ccb_pkg

/* verilog/ccb_top.sv */
/*
  Processor glue: clocks, resets, vector redirection, address and data
  buffering toward the expansion bus.
  Assumes the processor returns phase one and two from the supplied
  clock, and the card obeys the I/O selects.
*/
module ccb_top
(
  input  wire logic        I_CLOCK,
  input  wire logic        I_RST,
  input  wire logic        i_RESET_BUTTON_N,
  input  wire logic        i_CPU_PHASE_ONE,
  input  wire logic        i_CPU_PHASE_TWO_CLOCK,
  input  wire logic [15:0] i_CPU_ADDR,
  input  wire logic [7:0]  i_CPU_DATA,
  input  wire logic        i_CPU_RD_WR,
  input  wire logic [7:0]  i_BUS_DATA,
  output logic             o_CPU_CLOCK,
  output logic             o_SER_CLOCK,
  output logic             o_SER_RESET,
  output logic             o_CPU_RESET_N,
  output logic [15:0]      o_BUS_ADDR,
  output logic [7:0]       o_BUS_DATA,
  output logic             o_BUS_DATA_OE,
  output logic [7:0]       o_CPU_DATA,
  output logic             o_CPU_DATA_OE,
  output logic             o_BUS_RD_WR,
  output logic             o_IO_DATA_BUFFER_ENABLE_N,
  output logic             o_RAM_SEL_N,
  output logic             o_ROM_SEL_N
);

  // ----------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------
  function automatic logic is_io_page(input logic [15:0] a);
    return a[15:8] == ccb_pkg::IO_PAGE;
  endfunction

  localparam int DIV_W_L = ccb_pkg::DIV_W;

  function automatic logic [DIV_W_L-1:0] inc(input logic [DIV_W_L-1:0] v);
    return v + 1'b1;
  endfunction

  // ----------------------------------------------------------------------
  // Input synchronisers (three stages, second and third must agree)
  // ----------------------------------------------------------------------
  logic [2:0] btn_s1_reg, btn_s2_reg, btn_s3_reg;
  logic [2:0] btn_s1_next, btn_s2_next, btn_s3_next;
  logic       btn_n_reg, btn_n_next;
  logic       ph2_reg, ph2_next;
  logic       ph1_reg, ph1_next;
  logic [2:0] raw;

  assign raw = {i_RESET_BUTTON_N, i_CPU_PHASE_TWO_CLOCK, i_CPU_PHASE_ONE};

  always_comb
  begin
    btn_s1_next  = raw;
    btn_s2_next  = btn_s1_reg;
    btn_s3_next  = btn_s2_reg;
    btn_n_next   = btn_n_reg;
    ph2_next     = ph2_reg;
    ph1_next     = ph1_reg;
    if (btn_s2_reg[2] == btn_s3_reg[2]) btn_n_next = btn_s3_reg[2];
    if (btn_s2_reg[1] == btn_s3_reg[1]) ph2_next   = btn_s3_reg[1];
    if (btn_s2_reg[0] == btn_s3_reg[0]) ph1_next   = btn_s3_reg[0];
  end

  always_ff @(posedge I_CLOCK)
  begin
    if (I_RST)
    begin
      // Idle pin levels, so no false phase edge follows reset
      btn_s1_reg  <= 3'h5;
      btn_s2_reg  <= 3'h5;
      btn_s3_reg  <= 3'h5;
      btn_n_reg   <= 1'h1;
      ph2_reg     <= 1'h0;
      ph1_reg     <= 1'h1;
    end
    else
    begin
      btn_s1_reg  <= btn_s1_next;
      btn_s2_reg  <= btn_s2_next;
      btn_s3_reg  <= btn_s3_next;
      btn_n_reg   <= btn_n_next;
      ph2_reg     <= ph2_next;
      ph1_reg     <= ph1_next;
    end
  end

  // ----------------------------------------------------------------------
  // Clock dividers
  // ----------------------------------------------------------------------
  logic [DIV_W_L-1:0] cdiv_reg, cdiv_next, sdiv_reg, sdiv_next;
  logic               cclk_reg, cclk_next, sclk_reg, sclk_next;

  always_comb
  begin
    cdiv_next = inc(cdiv_reg);
    cclk_next = cclk_reg;
    sdiv_next = inc(sdiv_reg);
    sclk_next = sclk_reg;
    if (cdiv_reg == ccb_pkg::CPU_HALF_LAST)
    begin
      cdiv_next = '0;
      cclk_next = ~cclk_reg;
    end
    // Free running, unrelated to the processor clock
    if (sdiv_reg == ccb_pkg::SER_HALF_LAST)
    begin
      sdiv_next = '0;
      sclk_next = ~sclk_reg;
    end
  end

  always_ff @(posedge I_CLOCK)
  begin
    if (I_RST)
    begin
      cdiv_reg <= '0;
      cclk_reg <= 1'h0;
      sdiv_reg <= '0;
      sclk_reg <= 1'h0;
    end
    else
    begin
      cdiv_reg <= cdiv_next;
      cclk_reg <= cclk_next;
      sdiv_reg <= sdiv_next;
      sclk_reg <= sclk_next;
    end
  end

  // ----------------------------------------------------------------------
  // Reset stretch, replaces the RC delay
  // ----------------------------------------------------------------------
  logic [ccb_pkg::RST_W-1:0] rcnt_reg, rcnt_next;
  logic                      rst_act_reg, rst_act_next;

  always_comb
  begin
    rcnt_next    = rcnt_reg;
    rst_act_next = 1'b1;
    if (!btn_n_reg)
    begin
      rcnt_next = '0;
    end
    else if (rcnt_reg != ccb_pkg::RST_W'(ccb_pkg::RST_HOLD_CYC))
    begin
      rcnt_next = rcnt_reg + 1'b1;
    end
    else
    begin
      rst_act_next = 1'b0;
    end
  end

  always_ff @(posedge I_CLOCK)
  begin
    if (I_RST)
    begin
      rcnt_reg    <= '0;
      rst_act_reg <= 1'h1;
    end
    else
    begin
      rcnt_reg    <= rcnt_next;
      rst_act_reg <= rst_act_next;
    end
  end

  // ----------------------------------------------------------------------
  // Decode, buffers, vector redirection
  // ----------------------------------------------------------------------
  ccb_pkg::ccb_sel_t   sel;
  logic                vec_hit;
  logic [2:0]          vec_idx;
  logic [7:0]          vec_rdata;
  logic                vec_we;
  logic [15:0]         addr_next;
  logic [7:0]          bdat_next, cdat_next;
  logic                boe_next, coe_next;

  // Writes land only while phase two is high, when the data is valid
  assign vec_hit  = i_CPU_ADDR >= ccb_pkg::VEC_NMI_LO;
  assign vec_idx  = i_CPU_ADDR[2:0] - ccb_pkg::VEC_NMI_LO[2:0];
  assign vec_we   = ph2_reg && i_CPU_RD_WR &&
                    i_CPU_ADDR[15:3] == ccb_pkg::VEC_RAM_BASE[15:3];

  // Vector bytes FFFA..FFFF are served from the RAM copy so handlers can
  // be swapped in without a new ROM; boot vector is FFFA/FFFB
  ccb_vec_ram u_vec_ram
  (
    .i_clk   (I_CLOCK),
    .i_we    (vec_we),
    .i_addr  (vec_we ? i_CPU_ADDR[2:0] : vec_idx),
    .i_wdata (i_CPU_DATA),
    .o_rdata (vec_rdata)
  );

  always_comb
  begin
    sel.ram_sel_n = i_CPU_ADDR[15];
    sel.rom_sel_n = !i_CPU_ADDR[15] || vec_hit;
    sel.io_data_buffer_enable_n = 1'b1;
    if (is_io_page(i_CPU_ADDR) && !rst_act_reg)
    begin
      sel.io_data_buffer_enable_n = 1'b0;
      sel.ram_sel_n = 1'b1;
      sel.rom_sel_n = 1'b1;
    end
    addr_next = i_CPU_ADDR;
    bdat_next = i_CPU_DATA;
    cdat_next = vec_hit ? vec_rdata : i_BUS_DATA;
    // Off unless I/O page; card drive is its own duty
    boe_next = !sel.io_data_buffer_enable_n && i_CPU_RD_WR && ph2_reg &&
               !ph1_reg;
    coe_next = (!sel.io_data_buffer_enable_n && !i_CPU_RD_WR) || vec_hit;
  end

  always_ff @(posedge I_CLOCK)
  begin
    if (I_RST)
    begin
      o_BUS_ADDR                <= '0;
      o_BUS_DATA                <= '0;
      o_BUS_DATA_OE             <= 1'h0;
      o_CPU_DATA                <= '0;
      o_CPU_DATA_OE             <= 1'h0;
      o_BUS_RD_WR               <= 1'h1;
      o_IO_DATA_BUFFER_ENABLE_N <= 1'h1;
      o_RAM_SEL_N               <= 1'h1;
      o_ROM_SEL_N               <= 1'h1;
      o_CPU_CLOCK               <= 1'h0;
      o_SER_CLOCK               <= 1'h0;
      o_SER_RESET               <= 1'h1;
      o_CPU_RESET_N             <= 1'h0;
    end
    else
    begin
      o_BUS_ADDR                <= addr_next;
      o_BUS_DATA                <= bdat_next;
      o_BUS_DATA_OE             <= boe_next;
      o_CPU_DATA                <= cdat_next;
      o_CPU_DATA_OE             <= coe_next;
      o_BUS_RD_WR               <= i_CPU_RD_WR;
      o_IO_DATA_BUFFER_ENABLE_N <= sel.io_data_buffer_enable_n;
      o_RAM_SEL_N               <= sel.ram_sel_n;
      o_ROM_SEL_N               <= sel.rom_sel_n;
      o_CPU_CLOCK               <= cclk_reg;
      o_SER_CLOCK               <= sclk_reg;
      o_SER_RESET               <= rst_act_reg;
      o_CPU_RESET_N             <= !rst_act_reg;
    end
  end

endmodule // ccb_top

/* verilog/ccb_vec_ram.sv */
/*
  Small RAM holding the redirected interrupt vectors.
  Assumes one clock; read data is registered.
*/
module ccb_vec_ram
(
  input  wire logic       i_clk,
  input  wire logic       i_we,
  input  wire logic [2:0] i_addr,
  input  wire logic [7:0] i_wdata,
  output logic      [7:0] o_rdata
);

  logic [7:0] mem_reg [ccb_pkg::VEC_RAM_WORDS];

  always_ff @(posedge i_clk)
  begin
    if (i_we)
    begin
      mem_reg[i_addr] <= i_wdata;
    end
    o_rdata <= mem_reg[i_addr];
  end

endmodule // ccb_vec_ram
